// ---- logic/dcrc_defs.vh ----
// constants of the dma crc engine: offsets, fields, resets
// assumes inclusion by bare name from the engine's design files
`ifndef DCRC_DEFS_VH
`define DCRC_DEFS_VH

// ************
// register offsets
// ************
`define DCRC_ADDR_W 8
`define DCRC_OFF_CONTROL 8'h00
`define DCRC_OFF_SEED 8'h04
`define DCRC_OFF_TAPS 8'h08

// ************
// control fields
// ************
`define DCRC_BYTE_ORDER_HI 29
`define DCRC_BYTE_ORDER_LO 28
`define DCRC_WRITE_REORDER 27
`define DCRC_BIT_REFLECT 24
`define DCRC_POLY_LEN_HI 12
`define DCRC_POLY_LEN_LO 8
`define DCRC_ENGINE_ENABLE 7
`define DCRC_APPEND_MODE 6
`define DCRC_ALGO_TYPE 5
`define DCRC_CHAN_HI 2
`define DCRC_CHAN_LO 0
`define DCRC_CONTROL_MASK 32'h39001FE7

// ************
// byte order codes
// ************
`define DCRC_ORDER_NONE 2'h0
`define DCRC_ORDER_REV_BYTES 2'h1
`define DCRC_ORDER_SWAP_HALVES 2'h2
`define DCRC_ORDER_SWAP_IN_HALF 2'h3

// ************
// reset values and ip mask
// ************
`define DCRC_CONTROL_RESET 32'h00000000
`define DCRC_SEED_RESET 32'h00000000
`define DCRC_TAPS_RESET 32'h00000000
`define DCRC_IP_SUM_RESET 16'hFFFF
`define DCRC_IP_MASK 32'h0000FFFF

`endif

// ---- logic/dcrc_reorder.v ----
// byte reordering of one 32-bit source word
// assumes the select code comes from the control register
`timescale 1ns/1ps
`default_nettype none
`include "dcrc_defs.vh"

module dcrc_reorder (
  // word in and order code
  input wire [31:0] din,
  input wire [1:0] order,
  // reordered word
  output reg [31:0] dout
);

  always @* begin
    case (order)
      `DCRC_ORDER_NONE: dout = din;
      `DCRC_ORDER_REV_BYTES: dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
      `DCRC_ORDER_SWAP_HALVES: dout = {din[15:0], din[31:16]};
      `DCRC_ORDER_SWAP_IN_HALF: dout = {din[23:16], din[31:24], din[7:0], din[15:8]};
      default: dout = din;
    endcase
  end

endmodule
`default_nettype wire

// ---- logic/dcrc_lfsr.v ----
// one word step of the programmable lfsr crc, 32 bits per clock
// assumes state above the top stage is already zero
`timescale 1ns/1ps
`default_nettype none

module dcrc_lfsr (
  // present state and settings
  input wire [31:0] state,
  input wire [31:0] taps,
  input wire [4:0] top_stage,
  input wire reflect,
  // data word
  input wire [31:0] din,
  // state after the word
  output reg [31:0] next_state
);

  reg [31:0] s;
  reg [31:0] mask;
  reg fb;
  integer i;

  always @* begin
    s = state;
    mask = 32'hFFFFFFFF >> (5'h1F - top_stage);
    fb = 1'b0;
    for (i = 0; i < 32; i = i + 1) begin
      fb = s[top_stage] ^ (reflect ? din[i] : din[31 - i]);
      s = (s << 1) ^ (taps & {32{fb}});
      s = s & mask;
    end
    next_state = s;
  end

endmodule
`default_nettype wire

// ---- logic/dcrc_engine.v ----
// crc and ip checksum engine attached to one dma channel
// assumes an apb master on the same clock and a dma stream with no stall
//
// What this block does
// - enable bit routes the selected channel through the engine; clear passes unchanged
// - three-bit channel field picks which channel 0 to 7 is attached
// - type bit: one gives ip header checksum, zero gives lfsr crc
// - byte order: none, reverse bytes, swap halves, swap bytes per half
// - write-reorder set writes reordered data to destination, else unaltered
// - with write-reorder set, append mode cannot be set; no unaligned use
// - lfsr mode: bit order one feeds data lsb first, zero msb first
// - ip mode: bit order one reflects data bits before summing
// - lfsr mode: length field is polynomial length minus one; ip ignores it
// - append mode consumes data and writes the result at block end
// - append clear passes data on to destination with write-reorder applied
// - writing the data register seeds; reading returns current value
// - lfsr reads show zero above the programmed polynomial length
// - ip mode reads keep upper sixteen bits zero
// - ip mode stores and returns the value in ones-complement form
// - unimplemented control bits ignore writes and read zero
// - each tap bit set xors feedback into that stage
// - ip mode ignores the tap register
`timescale 1ns/1ps
`default_nettype none
`include "dcrc_defs.vh"

module dcrc_engine (
  // clock and reset
  input wire CLK,
  input wire RST_B,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // dma source stream
  input wire SRC_VALID,
  input wire [2:0] SRC_CHAN,
  input wire [31:0] SRC_DATA,
  input wire SRC_LAST,
  // dma destination stream
  output reg DST_VALID,
  output reg [2:0] DST_CHAN,
  output reg [31:0] DST_DATA,
  output reg DST_RESULT
);

  // ************
  // register state
  // ************
  reg [31:0] crc_control;
  reg [31:0] crc_feedback_tap_enable;
  reg [31:0] lfsr_state;
  reg [15:0] ip_sum;
  reg result_pend;
  reg [2:0] result_chan;

  // ************
  // control fields
  // ************
  wire [1:0] byte_order_select;
  wire write_reorder_enable;
  wire bit_reflect_select;
  wire [4:0] poly_length_minus_one;
  wire engine_enable;
  wire append_result_mode;
  wire algorithm_type_select;
  wire [2:0] attached_channel_select;

  assign byte_order_select = crc_control[`DCRC_BYTE_ORDER_HI:`DCRC_BYTE_ORDER_LO];
  assign write_reorder_enable = crc_control[`DCRC_WRITE_REORDER];
  assign bit_reflect_select = crc_control[`DCRC_BIT_REFLECT];
  assign poly_length_minus_one = crc_control[`DCRC_POLY_LEN_HI:`DCRC_POLY_LEN_LO];
  assign engine_enable = crc_control[`DCRC_ENGINE_ENABLE];
  assign append_result_mode = crc_control[`DCRC_APPEND_MODE];
  assign algorithm_type_select = crc_control[`DCRC_ALGO_TYPE];
  assign attached_channel_select = crc_control[`DCRC_CHAN_HI:`DCRC_CHAN_LO];

  // ************
  // apb decode
  // ************
  wire apb_access;
  wire apb_done;
  wire apb_write;
  wire hit_control;
  wire hit_seed;
  wire hit_taps;
  wire hit_any;

  assign apb_access = PSEL & PENABLE;
  assign apb_done = apb_access & PREADY;
  assign apb_write = apb_done & PWRITE & hit_any;
  assign hit_control = (PADDR == `DCRC_OFF_CONTROL);
  assign hit_seed = (PADDR == `DCRC_OFF_SEED);
  assign hit_taps = (PADDR == `DCRC_OFF_TAPS);
  assign hit_any = hit_control | hit_seed | hit_taps;

  // ************
  // source word handling
  // ************
  wire attached;
  wire [31:0] ordered;
  wire [31:0] lfsr_next;
  wire [31:0] len_mask;

  assign attached = SRC_VALID & engine_enable & (SRC_CHAN == attached_channel_select);
  assign len_mask = 32'hFFFFFFFF >> (5'h1F - poly_length_minus_one);

  dcrc_reorder u_reorder (
    .din(SRC_DATA),
    .order(byte_order_select),
    .dout(ordered)
  );

  dcrc_lfsr u_lfsr (
    .state(lfsr_state),
    .taps(crc_feedback_tap_enable),
    .top_stage(poly_length_minus_one),
    .reflect(bit_reflect_select),
    .din(ordered),
    .next_state(lfsr_next)
  );

  // ************
  // ip checksum step
  // ************
  reg [15:0] half_hi;
  reg [15:0] half_lo;
  reg [17:0] wide_sum;
  reg [15:0] next_ip_sum;
  integer b;

  always @* begin
    for (b = 0; b < 16; b = b + 1) begin
      half_hi[b] = bit_reflect_select ? ordered[31 - b] : ordered[16 + b];
      half_lo[b] = bit_reflect_select ? ordered[15 - b] : ordered[b];
    end
    wide_sum = {2'h0, ip_sum} + {2'h0, half_hi} + {2'h0, half_lo};
    wide_sum = {2'h0, wide_sum[15:0]} + {16'h0000, wide_sum[17:16]};
    next_ip_sum = wide_sum[15:0] + {15'h0000, wide_sum[16]};
  end

  // ************
  // readback value
  // ************
  reg [31:0] current_value;

  always @* begin
    if (algorithm_type_select) begin
      current_value = {16'h0000, ~ip_sum};
    end else begin
      current_value = lfsr_state & len_mask;
    end
  end

  // ************
  // apb slave
  // ************
  reg [31:0] next_prdata;

  always @* begin
    if (hit_control) begin
      next_prdata = crc_control & `DCRC_CONTROL_MASK;
    end else if (hit_seed) begin
      next_prdata = current_value;
    end else if (hit_taps) begin
      next_prdata = crc_feedback_tap_enable;
    end else begin
      next_prdata = 32'h00000000;
    end
  end

  // ************
  // apb answer timing
  // ************
  wire apb_first;
  wire next_pready;
  wire next_pslverr;
  wire read_capture;

  // one wait state: answer in the second access cycle
  assign apb_first = apb_access & ~PREADY;
  assign next_pready = apb_first;
  assign next_pslverr = apb_first & ~hit_any;
  assign read_capture = apb_first & ~PWRITE;

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      if (read_capture) begin
        PRDATA <= next_prdata;
      end
    end
  end

  // ************
  // control register write value
  // ************
  reg [31:0] next_control;

  always @* begin
    next_control = PWDATA & `DCRC_CONTROL_MASK;
    if (PWDATA[`DCRC_WRITE_REORDER]) begin
      next_control[`DCRC_APPEND_MODE] = 1'b0;
    end
  end

  // ************
  // register write path
  // ************
  reg [31:0] next_taps;
  reg [31:0] next_control_reg;

  always @* begin
    next_control_reg = crc_control;
    next_taps = crc_feedback_tap_enable;
    if (apb_write & hit_control) begin
      next_control_reg = next_control;
    end
    if (apb_write & hit_taps) begin
      next_taps = PWDATA;
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      crc_control <= `DCRC_CONTROL_RESET;
      crc_feedback_tap_enable <= `DCRC_TAPS_RESET;
    end else begin
      crc_control <= next_control_reg;
      crc_feedback_tap_enable <= next_taps;
    end
  end

  // ************
  // generator state
  // ************
  reg [31:0] next_lfsr_state;
  reg [15:0] next_ip_state;
  wire seed_write;
  wire step_ip;
  wire step_lfsr;

  assign seed_write = apb_write & hit_seed;
  assign step_ip = attached & algorithm_type_select;
  assign step_lfsr = attached & ~algorithm_type_select;

  // ************
  // generator next value
  // ************
  // a seed write wins over a word in the same cycle
  always @* begin
    next_lfsr_state = lfsr_state;
    next_ip_state = ip_sum;
    if (seed_write) begin
      next_lfsr_state = PWDATA;
      next_ip_state = ~PWDATA[15:0];
    end else if (step_ip) begin
      next_ip_state = next_ip_sum;
    end else if (step_lfsr) begin
      next_lfsr_state = lfsr_next;
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lfsr_state <= `DCRC_SEED_RESET;
      ip_sum <= `DCRC_IP_SUM_RESET;
    end else begin
      lfsr_state <= next_lfsr_state;
      ip_sum <= next_ip_state;
    end
  end

  // ************
  // destination stream
  // ************
  reg next_dst_valid;
  reg [2:0] next_dst_chan;
  reg [31:0] next_dst_data;
  reg next_dst_result;
  wire consume;
  wire end_of_block;

  assign consume = attached & append_result_mode;
  assign end_of_block = attached & SRC_LAST;

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      result_pend <= 1'b0;
      result_chan <= 3'h0;
    end else begin
      result_pend <= consume & SRC_LAST;
      if (end_of_block) begin
        result_chan <= SRC_CHAN;
      end
    end
  end

  // ************
  // result slot and pass path
  // ************
  // result slot takes the cycle two after the last word
  always @* begin
    next_dst_valid = SRC_VALID & ~consume;
    next_dst_chan = SRC_CHAN;
    next_dst_data = SRC_DATA;
    next_dst_result = 1'b0;
    if (attached & write_reorder_enable) begin
      next_dst_data = ordered;
    end
    if (result_pend) begin
      next_dst_valid = 1'b1;
      next_dst_chan = result_chan;
      next_dst_data = current_value;
      next_dst_result = 1'b1;
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DST_VALID <= 1'b0;
      DST_CHAN <= 3'h0;
      DST_DATA <= 32'h00000000;
      DST_RESULT <= 1'b0;
    end else begin
      DST_VALID <= next_dst_valid;
      DST_CHAN <= next_dst_chan;
      DST_DATA <= next_dst_data;
      DST_RESULT <= next_dst_result;
    end
  end

endmodule
`default_nettype wire

// ---- bench/dcrc_engine_asserts.sv ----
// checker on the crc engine ports
// assumes a bind onto dcrc_engine, one clock
`timescale 1ns/1ps
`default_nettype none
`include "dcrc_defs.vh"
module dcrc_asserts (
  // clock and apb
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // streams
  input wire logic SRC_VALID,
  input wire logic [2:0] SRC_CHAN,
  input wire logic SRC_LAST,
  input wire logic DST_VALID,
  input wire logic [2:0] DST_CHAN,
  input wire logic DST_RESULT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire hit = PADDR == 8'h00 || PADDR == 8'h04 || PADDR == 8'h08;
  wire rd_ctl = PREADY && !PWRITE && PADDR == `DCRC_OFF_CONTROL;
  property p_rdy; $rose(PENABLE) |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("late ready");
  property p_one; PREADY |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_err; PREADY |-> PSLVERR == !hit; endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_unm; PSLVERR && !PWRITE |-> PRDATA == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  property p_ctl; rd_ctl |-> (PRDATA & ~`DCRC_CONTROL_MASK) == 32'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control spare bits");
  property p_app; rd_ctl && PRDATA[27] |-> !PRDATA[6]; endproperty
  a_app: assert property (p_app) else $error("append with reorder");
  property p_pass; DST_VALID && !DST_RESULT |-> $past(SRC_VALID) && DST_CHAN == $past(SRC_CHAN);
  endproperty
  a_pass: assert property (p_pass) else $error("pass word");
  property p_res; DST_RESULT |-> DST_VALID && $past(SRC_VALID, 2) && $past(SRC_LAST, 2);
  endproperty
  a_res: assert property (p_res) else $error("result slot");
  c_res: cover property (DST_RESULT);
  c_err: cover property (PSLVERR);
  c_app: cover property (rd_ctl && PRDATA[27]);
endmodule
bind dcrc_engine dcrc_asserts u_chk (.CLK, .RST_B, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY,
  .PSLVERR, .SRC_VALID, .SRC_CHAN, .SRC_LAST, .DST_VALID, .DST_CHAN, .DST_RESULT);
`default_nettype wire

// ---- bench/dcrc_src_model.sv ----
// dma source channel model, one word per call
// assumes the engine never stalls the stream
`timescale 1ns/1ps
`default_nettype none
module dcrc_src_model (
  // clock
  input wire logic CLK,
  // source words
  output logic SRC_VALID = 1'b0,
  output logic [2:0] SRC_CHAN = 3'h0,
  output logic [31:0] SRC_DATA = 32'h0,
  output logic SRC_LAST = 1'b0
);
  task automatic send(input logic [2:0] c, input logic [31:0] x, input logic l, input int g);
    repeat (g) @(posedge CLK);
    @(posedge CLK);
    SRC_VALID <= 1'b1;
    SRC_CHAN <= c;
    SRC_DATA <= x;
    SRC_LAST <= l;
    @(posedge CLK);
    SRC_VALID <= 1'b0;
    SRC_DATA <= ~x;
    SRC_LAST <= 1'b0;
    if (l) repeat (2) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the crc engine
// assumes the source model and checker beside it
`timescale 1ns/1ps
`default_nettype none
`include "dcrc_defs.vh"
module tb_top;
  logic CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, SRC_DATA, DST_DATA, tp, st, d;
  logic PREADY, PSLVERR, SRC_VALID, SRC_LAST, DST_VALID, DST_RESULT, w, rf, en, ap, ty;
  logic [2:0] SRC_CHAN, DST_CHAN, ch;
  logic [15:0] ip;
  logic [4:0] pl;
  logic [1:0] o;
  logic [33:0] aq[$];
  logic [35:0] dq[$];
  int mismatches = 0, tests_run = 0;
  always #2.5 CLK = ~CLK;
  dcrc_engine u_dcrc_engine (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .SRC_VALID, .SRC_CHAN, .SRC_DATA, .SRC_LAST, .DST_VALID, .DST_CHAN,
    .DST_DATA, .DST_RESULT);
  dcrc_src_model u_src (.CLK, .SRC_VALID, .SRC_CHAN, .SRC_DATA, .SRC_LAST);
  task automatic bad(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [33:0] e);
    tests_run++;
    if (PSLVERR !== e[32] || (e[33] && PRDATA !== e[31:0])) bad("apb answer");
  endtask
  task automatic cmp_dst(input logic [35:0] e);
    tests_run++;
    if ({DST_CHAN, DST_DATA, DST_RESULT} !== e) bad("destination word");
  endtask
  always @(posedge CLK) begin
    if (PREADY === 1'b1) cmp_rd(aq.pop_front());
    if (DST_VALID === 1'b1) cmp_dst(dq.pop_front());
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v,
    input logic [33:0] e);
    int n = 0;
    aq.push_back(e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= v;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      bad("apb timeout");
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'h2, x});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 34'h0);
  endtask
  // ************
  // expected stream words and engine state
  // ************
  task automatic word(input logic [2:0] c, input logic [31:0] x, input logic l);
    logic [31:0] r, q;
    logic [17:0] t;
    r = x;
    if (o[0]) r = {r[23:16], r[31:24], r[7:0], r[15:8]};
    if (^o) r = {r[15:0], r[31:16]};
    q = rf ? {<<{r}} : r;
    if (en && c == ch) begin
      if (ty) begin
        t = ip + q[31:16] + q[15:0];
        t = t[15:0] + t[17:16];
        ip = t[15:0] + t[16];
      end else for (int k = 31; k >= 0; k--)
        st = ((st << 1) ^ (tp & {32{st[pl] ^ q[k]}})) & (32'hFFFFFFFF >> (31 - pl));
      if (!ap) dq.push_back({c, w ? r : x, 1'b0});
      else if (l) dq.push_back({c, ty ? {16'h0, ~ip} : st, 1'b1});
    end else dq.push_back({c, x, 1'b0});
    u_src.send(c, x, l, $urandom_range(2));
  endtask
  task automatic tally_and_finish();
    if (aq.size() + dq.size() != 0) bad("results missing");
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h752C));
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    rd(`DCRC_OFF_CONTROL, `DCRC_CONTROL_RESET);
    rd(`DCRC_OFF_SEED, `DCRC_SEED_RESET);
    rd(`DCRC_OFF_TAPS, `DCRC_TAPS_RESET);
    apb(1'b0, 8'h0C, 32'h0, 34'h300000000);
    wr(`DCRC_OFF_CONTROL, 32'hFFFFFFFF);
    rd(`DCRC_OFF_CONTROL, `DCRC_CONTROL_MASK & 32'hFFFFFFBF);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      {w, rf, pl} = 7'($urandom);
      o = i[1:0];
      tp = $urandom;
      ch = i[2:0];
      ty = i[3];
      en = i != 5;
      ap = i[0] && !w;
      wr(`DCRC_OFF_CONTROL, {2'h0, o, w, 2'h0, rf, 11'h0, pl, en, i[0], ty, 2'h0, ch});
      wr(`DCRC_OFF_TAPS, tp);
      rd(`DCRC_OFF_TAPS, tp);
      d = $urandom;
      wr(`DCRC_OFF_SEED, d);
      st = d & (32'hFFFFFFFF >> (31 - pl));
      ip = ~d[15:0];
      rd(`DCRC_OFF_SEED, ty ? {16'h0, ~ip} : st);
      word(ch + 3'h1, $urandom, 1'b0);
      repeat (3) word(ch, $urandom, 1'b0);
      word(ch, $urandom, 1'b1);
      rd(`DCRC_OFF_SEED, ty ? {16'h0, ~ip} : st);
      $display("stream case %0d done", i);
    end
    repeat (4) @(posedge CLK);
    tally_and_finish();
  end
endmodule
`default_nettype wire
